// File: hw/tsf_finder.sv
// Purpose: segment finder back end: masks, pixel register, pipeline, level 2 buffers, diagnostics
// Assumes: wire and flag inputs come from logic on clk; one cycle per sub-slice
// Notes:   pipeline memory is read before write in one edge instead of a falling-edge read
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module tsf_finder #(
    parameter int                       MISS_ALLOW = 3,
    parameter tsf_pkg::tsf_variant_type VARIANT    = tsf_pkg::VAR_NORMAL
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    tsf_if.dev               bus,
    input  wire logic [69:0] wire_in,
    input  wire logic        frame_in,
    input  wire logic        beam_in,
    input  wire logic        err_in,
    input  wire logic        run_in,
    input  wire logic        l1_accept,
    input  wire logic [1:0]  l1_addr,
    output logic      [11:0] pixel_out,
    output logic             frame_out,
    output logic             beam_out,
    output logic             err_out,
    output logic             link_valid
);
    localparam logic [3:0] MISS_LIMIT = 4'(MISS_ALLOW);
    localparam bit CAP_ON = (VARIANT == tsf_pkg::VAR_CAPTURE) || (VARIANT == tsf_pkg::VAR_PASS);
    localparam bit REP_ON = (VARIANT == tsf_pkg::VAR_REPLAY);

    tsf_pkg::tsf_sub_type sub_q;
    tsf_pkg::tsf_l2_type  l2_q;
    logic        run_q;
    logic        l1_acc_q;
    logic [1:0]  l1_addr_q;
    logic [1:0]  l2_sel_q;
    logic [69:0] slice_q;
    logic [2:0]  flg_q, flg_s1_q, flg_s2_q;
    logic        act_q, act_s1_q, act_s2_q;
    logic [79:0] dead_q;
    logic [7:0]  depth_q;
    logic        loop_q, loop_prev_q;
    logic [7:0]  ptr_q;
    logic [26:0] pipe_out_q;
    logic [26:0] pipe_mem [tsf_pkg::PIPE_ENTRIES];
    logic [107:0] l2_buf_q [tsf_pkg::L2_BUFS];
    logic [31:0] diag_mem [tsf_pkg::PIPE_ENTRIES];
    logic [31:0] diag_rd_q;
    logic        arm_q, cap_on_q, rep_vld_q;
    logic [8:0]  cap_cnt_q;
    logic [7:0]  rep_ptr_q;
    logic [15:0] rdata_q;
    logic [2:0]  grp_q [tsf_pkg::MASK_N][tsf_pkg::GROUP_N];
    logic [23:0] hit_q;
    logic [11:0] pixel_or;

    function automatic logic [2:0] count_off(input logic [3:0] w);
        count_off = 3'(!w[0]) + 3'(!w[1]) + 3'(!w[2]) + 3'(!w[3]);
    endfunction

    // run and frame-start start a slice
    wire go          = (sub_q == tsf_pkg::SUB0) && run_q && frame_in;
    wire active      = go || (sub_q != tsf_pkg::SUB0);
    wire wr_en       = bus.cs && !bus.rd_high && bus.wr_strobe;
    wire diag_hit    = (bus.addr[9] == tsf_pkg::REG_DIAG_PAGE);
    wire l2_hit      = (bus.addr[9:5] == tsf_pkg::REG_L2_PAGE);
    wire [7:0] d_idx = bus.addr[8:1];
    wire [1:0] l2_b  = bus.addr[4:3];
    wire [1:0] l2_w  = bus.addr[2:1];
    wire [26:0] l2_word  = l2_buf_q[l2_b][27 * l2_w +: 27];
    wire [31:0] l2_wide  = {5'h00, l2_word};
    wire [31:0] diag_wd  = diag_mem[d_idx];
    wire [79:0] dead_rd  = {10'h000, dead_q[69:0]};
    wire [2:0]  dead_i   = 3'(bus.addr[2:0]);
    wire        dead_hit = (bus.addr < 10'(tsf_pkg::DEAD_WORDS));
    wire [15:0] rd_mux   = diag_hit ? (bus.addr[0] ? diag_wd[31:16] : diag_wd[15:0]) :
                           l2_hit   ? (bus.addr[0] ? l2_wide[31:16] : l2_wide[15:0]) :
                           dead_hit ? dead_rd[16 * dead_i +: 16] :
                           (bus.addr == tsf_pkg::REG_DEPTH) ? {8'h00, depth_q} :
                           (bus.addr == tsf_pkg::REG_LOOP)  ? {15'h0000, loop_q} : 16'h0000;
    // wrap on equal; at or above covers a lowered depth
    wire ptr_wrap    = (ptr_q >= depth_q);
    wire cap_trig    = CAP_ON && arm_q && loop_q && run_q && flg_q[tsf_pkg::FLG_BEAM] && flg_q[tsf_pkg::FLG_FRAME];
    wire cap_we      = cap_on_q && !cap_cnt_q[8];
    wire host_dw     = wr_en && diag_hit;

    assign bus.rdata = rdata_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sub_q     <= tsf_pkg::SUB0;
            run_q     <= 1'b0;
            l1_acc_q  <= 1'b0;
            l1_addr_q <= 2'h0;
        end else begin
            run_q <= run_in;
            case (sub_q)
                tsf_pkg::SUB0: sub_q <= go ? tsf_pkg::SUB1 : tsf_pkg::SUB0;
                tsf_pkg::SUB1: sub_q <= tsf_pkg::SUB2;
                tsf_pkg::SUB2: sub_q <= tsf_pkg::SUB3;
                default:       sub_q <= tsf_pkg::SUB0;
            endcase
            // accept taken only at slice start
            l1_acc_q <= go && l1_accept;
            if (go) begin
                l1_addr_q <= l1_addr;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            slice_q  <= 70'h0;
            flg_q    <= 3'h0;
            flg_s1_q <= 3'h0;
            flg_s2_q <= 3'h0;
            act_q    <= 1'b0;
            act_s1_q <= 1'b0;
            act_s2_q <= 1'b0;
        end else begin
            slice_q  <= wire_in | dead_q[69:0];
            flg_q    <= {err_in, beam_in, frame_in};
            flg_s1_q <= flg_q;
            flg_s2_q <= flg_s1_q;
            act_q    <= active;
            act_s1_q <= act_q;
            act_s2_q <= act_s1_q;
        end
    end

    genvar m, g, p;
    generate
        for (m = 0; m < tsf_pkg::MASK_N; m++) begin : g_mask
            for (g = 0; g < tsf_pkg::GROUP_N; g++) begin : g_grp
                wire [3:0] w4;
                for (p = 0; p < tsf_pkg::GROUP_W; p++) begin : g_w
                    assign w4[p] = slice_q[(m * tsf_pkg::MASK_STRIDE +
                                   (g * tsf_pkg::GROUP_W + p) * tsf_pkg::WIRE_STRIDE) % tsf_pkg::WIRE_W];
                end
                always_ff @(posedge clk or negedge rst_b) begin
                    if (!rst_b) grp_q[m][g] <= 3'h0;
                    else        grp_q[m][g] <= count_off(w4);
                end
            end
            wire [3:0] miss = 4'(grp_q[m][0]) + 4'(grp_q[m][1]) + 4'(grp_q[m][2]);
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) hit_q[m] <= 1'b0;
                else        hit_q[m] <= (miss <= MISS_LIMIT);
            end
        end
        for (p = 0; p < tsf_pkg::PIX_W; p++) begin : g_pix
            assign pixel_or[p] = hit_q[p] | hit_q[p + tsf_pkg::PIX_W];
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pixel_out  <= 12'h000;
            frame_out  <= 1'b0;
            beam_out   <= 1'b0;
            err_out    <= 1'b0;
            link_valid <= 1'b0;
        end else if (REP_ON) begin
            pixel_out  <= diag_rd_q[11:0];
            {err_out, beam_out, frame_out} <= diag_rd_q[14:12];
            link_valid <= rep_vld_q;
        end else if (VARIANT == tsf_pkg::VAR_PASS) begin
            pixel_out  <= slice_q[11:0];
            {err_out, beam_out, frame_out} <= flg_q;
            link_valid <= act_q;
        end else begin
            pixel_out  <= pixel_or;
            {err_out, beam_out, frame_out} <= flg_s2_q;
            link_valid <= act_s2_q;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dead_q      <= tsf_pkg::DEAD_RESET;
            depth_q     <= tsf_pkg::DEPTH_RESET;
            loop_q      <= 1'b0;
            loop_prev_q <= 1'b0;
            rdata_q     <= 16'h0000;
        end else begin
            loop_prev_q <= loop_q;
            rdata_q     <= rd_mux;
            if (wr_en && dead_hit) begin
                dead_q[16 * dead_i +: 16] <= bus.wdata;
            end else if (wr_en && bus.addr == tsf_pkg::REG_DEPTH) begin
                depth_q <= bus.wdata[7:0];
            end else if (wr_en && bus.addr == tsf_pkg::REG_LOOP) begin
                loop_q <= bus.wdata[0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_q <= 8'h00;
        end else begin
            ptr_q <= ptr_wrap ? 8'h00 : ptr_q + 8'h01;
        end
    end

    // old entry read, new one stored
    always_ff @(posedge clk) begin
        pipe_out_q      <= pipe_mem[ptr_q];
        pipe_mem[ptr_q] <= {flg_q, slice_q[23:0]};
    end

    // buffer chosen by level 1 address
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            l2_q     <= tsf_pkg::L2_W0;
            l2_sel_q <= 2'h0;
            for (int i = 0; i < tsf_pkg::L2_BUFS; i++) l2_buf_q[i] <= 108'h0;
        end else begin
            case (l2_q)
                tsf_pkg::L2_W0: begin
                    if (l1_acc_q) begin
                        l2_buf_q[l1_addr_q][26:0] <= pipe_out_q;
                        l2_sel_q <= l1_addr_q;
                        l2_q     <= tsf_pkg::L2_W1;
                    end
                end
                tsf_pkg::L2_W1: begin
                    l2_buf_q[l2_sel_q][53:27] <= pipe_out_q;
                    l2_q <= tsf_pkg::L2_W2;
                end
                tsf_pkg::L2_W2: begin
                    l2_buf_q[l2_sel_q][80:54] <= pipe_out_q;
                    l2_q <= tsf_pkg::L2_W3;
                end
                default: begin
                    l2_buf_q[l2_sel_q][107:81] <= pipe_out_q;
                    l2_q <= tsf_pkg::L2_W0;
                end
            endcase
        end
    end

    // arm on loop rise, skip trigger slice
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            arm_q     <= 1'b0;
            cap_on_q  <= 1'b0;
            cap_cnt_q <= 9'h000;
            rep_ptr_q <= 8'h00;
            rep_vld_q <= 1'b0;
        end else begin
            if (!loop_q) begin
                arm_q    <= 1'b0;
                cap_on_q <= 1'b0;
            end else if (loop_q && !loop_prev_q) begin
                arm_q <= 1'b1;
            end else if (cap_trig) begin
                arm_q     <= 1'b0;
                cap_on_q  <= 1'b1;
                cap_cnt_q <= 9'h000;
            end else if (cap_we) begin
                cap_cnt_q <= cap_cnt_q + 9'h001;
            end
            rep_vld_q <= REP_ON && loop_q;
            if (REP_ON && loop_q) begin
                rep_ptr_q <= rep_ptr_q + 8'h01;
            end
        end
    end

    // capture has priority; host must drop loop before touching memory
    always_ff @(posedge clk) begin
        diag_rd_q <= diag_mem[rep_ptr_q];
        if (cap_we) begin
            diag_mem[cap_cnt_q[7:0]] <= {5'h00, flg_q, slice_q[23:0]};
        end else if (host_dw && bus.addr[0]) begin
            diag_mem[d_idx][31:16] <= bus.wdata;
        end else if (host_dw) begin
            diag_mem[d_idx][15:0] <= bus.wdata;
        end
    end
endmodule

// File: hw/tsf_pkg.sv
// Purpose: shared constants for the segment finder back end and its control-port host
// Assumes: one 10 MHz clock; one clock cycle stands for one sub-slice
// Notes:   control-port offsets are word addresses on a 16-bit data path
package tsf_pkg;
    localparam int CLK_PERIOD_NS  = 100;
    localparam int SUBSLICE_NS    = 33;
    localparam int SUBSLICE_CYC   = (SUBSLICE_NS / CLK_PERIOD_NS) < 1 ? 1 : (SUBSLICE_NS / CLK_PERIOD_NS);
    localparam int MASK_STAGES    = 2;
    localparam int VALID_DELAY    = 3;

    localparam int WIRE_W         = 70;
    localparam int DEAD_W         = 70;
    localparam int DEAD_WORDS     = 5;
    localparam int CELL_W         = 24;
    localparam int FLAG_W         = 3;
    localparam int SLICE_W        = 27;
    localparam int PIX_W          = 12;
    localparam int MASK_N         = 24;
    localparam int MASK_WIRES     = 12;
    localparam int GROUP_W        = 4;
    localparam int GROUP_N        = 3;
    localparam int MASK_STRIDE    = 3;
    localparam int WIRE_STRIDE    = 5;

    localparam int PIPE_ENTRIES   = 256;
    localparam int PTR_W          = 8;
    localparam int DIAG_W         = 32;
    localparam int CAP_CNT_W      = 9;
    localparam int L2_BUFS        = 4;
    localparam int L2_WORDS       = 4;
    localparam int L2_BUF_W       = 108;
    localparam int L2_SEL_W       = 4;

    localparam int FLG_FRAME      = 0;
    localparam int FLG_BEAM       = 1;
    localparam int FLG_ERR        = 2;

    localparam int ADDR_W         = 10;
    localparam int DATA_W         = 16;
    localparam logic [9:0] REG_DEAD0    = 10'h000;
    localparam logic [9:0] REG_DEPTH    = 10'h005;
    localparam logic [9:0] REG_LOOP     = 10'h006;
    localparam logic [4:0] REG_L2_PAGE  = 5'h01;
    localparam logic [0:0] REG_DIAG_PAGE = 1'h1;

    localparam logic [7:0]  DEPTH_RESET = 8'h00;
    localparam logic [79:0] DEAD_RESET  = 80'h0;

    localparam int AVS_ADDR_W     = 11;
    localparam logic [10:0] HOST_REG_COUNT = 11'h400;

    typedef enum { VAR_NORMAL, VAR_CAPTURE, VAR_REPLAY, VAR_PASS } tsf_variant_type;
    typedef enum { SUB0, SUB1, SUB2, SUB3 } tsf_sub_type;
    typedef enum { L2_W0, L2_W1, L2_W2, L2_W3 } tsf_l2_type;
    typedef enum { H_IDLE, H_SETUP, H_STROBE, H_DONE } tsf_host_type;
endpackage

// File: hw/tsf_if.sv
// Purpose: parallel control port between the finder back end and its host
// Assumes: both ends on clk; host drives all but rdata
// Notes:   rd_high high means read, low means write
`timescale 1ns/10ps
interface tsf_if;
    logic        cs;
    logic        rd_high;
    logic        wr_strobe;
    logic [9:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport dev  (input cs, input rd_high, input wr_strobe, input addr, input wdata, output rdata);
    modport host (output cs, output rd_high, output wr_strobe, output addr, output wdata, input rdata);
endinterface

// File: hw/tsf_host.sv
// Purpose: Avalon-MM slave that turns bus words into control-port cycles
// Assumes: device answers reads from the address alone, one cycle late
// Notes:   word 0x400 is a local read-only transfer counter
`timescale 1ns/10ps
module tsf_host (
    input  wire logic        clk,
    input  wire logic        rst_b,
    tsf_if.host              bus,
    input  wire logic [10:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);
    tsf_pkg::tsf_host_type state_q;
    logic        is_write_q;
    logic [15:0] count_q;
    logic [31:0] rdata_q;

    wire req       = avs_read | avs_write;
    wire local_hit = (avs_address == tsf_pkg::HOST_REG_COUNT);

    assign avs_waitrequest = (state_q != tsf_pkg::H_DONE);
    assign avs_readdata    = rdata_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q       <= tsf_pkg::H_IDLE;
            is_write_q    <= 1'b0;
            count_q       <= 16'h0000;
            rdata_q       <= 32'h00000000;
            bus.cs        <= 1'b0;
            bus.rd_high   <= 1'b1;
            bus.wr_strobe <= 1'b0;
            bus.addr      <= 10'h000;
            bus.wdata     <= 16'h0000;
        end else begin
            case (state_q)
                tsf_pkg::H_IDLE: begin
                    if (req) begin
                        is_write_q <= avs_write;
                        if (local_hit) begin
                            rdata_q <= {16'h0000, count_q};
                            state_q <= tsf_pkg::H_DONE;
                        end else begin
                            bus.cs      <= 1'b1;
                            bus.addr    <= avs_address[9:0];
                            bus.rd_high <= avs_read;
                            bus.wdata   <= avs_writedata[15:0];
                            state_q     <= tsf_pkg::H_SETUP;
                        end
                    end
                end
                tsf_pkg::H_SETUP: begin
                    bus.wr_strobe <= is_write_q;
                    state_q       <= tsf_pkg::H_STROBE;
                end
                tsf_pkg::H_STROBE: begin
                    rdata_q       <= {16'h0000, bus.rdata};
                    bus.wr_strobe <= 1'b0;
                    bus.cs        <= 1'b0;
                    bus.rd_high   <= 1'b1;
                    count_q       <= count_q + 16'h0001;
                    state_q       <= tsf_pkg::H_DONE;
                end
                default: begin
                    state_q <= tsf_pkg::H_IDLE;
                end
            endcase
        end
    end
endmodule

// File: verification/tsf_bus_properties.sv
// Purpose: control-port checks on the carrier
// Assumes: one clock, reset active low
// Notes: depth shadow kept here, not read from design
`timescale 1ns/10ps
module tsf_bus_properties (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        cs,
    input wire logic        rd_high,
    input wire logic        wr_strobe,
    input wire logic [9:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata
);
    logic [7:0] dep_q;
    wire        dep_wr = cs && !rd_high && wr_strobe && (addr == 10'h005);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dep_q <= 8'h00;
        end else if (dep_wr) begin
            dep_q <= wdata[7:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_STB_QUAL: assert property (wr_strobe |-> cs && !rd_high)
        else $error("strobe outside write cycle");
    AST_STB_PULSE: assert property (wr_strobe |=> !wr_strobe)
        else $error("strobe longer than one cycle");
    AST_WR_SEQ: assert property ($rose(cs) && !rd_high |=> wr_strobe)
        else $error("no strobe after write select");
    AST_WR_END: assert property (wr_strobe |=> !cs && rd_high)
        else $error("select held after strobe");
    AST_ADDR_HOLD: assert property (cs |=> !cs || $stable(addr))
        else $error("address moved under select");
    AST_WDATA_HOLD: assert property (cs && !rd_high |=> !cs || $stable(wdata))
        else $error("write data moved under select");
    AST_DEPTH_RD: assert property (addr == 10'h005 && !wr_strobe |=> rdata == {8'h00, dep_q})
        else $error("depth readback wrong");
    AST_DEAD_TOP: assert property (addr == 10'h004 |=> rdata[15:6] == 10'h000)
        else $error("dead mask bits above 69 set");
    AST_UNMAPPED: assert property (addr == 10'h007 |=> rdata == 16'h0000)
        else $error("unmapped word not zero");
    AST_L2_WIDTH: assert property (addr[9:5] == 5'h01 && addr[0] |=> rdata[15:11] == 5'h00)
        else $error("buffer word wider than 27 bits");
endmodule

// File: verification/tb_track_segment_finder_backend.sv
// Purpose: bench for finder back end and its host
// Assumes: inputs driven just after rising edge
// Notes: register rows in a table, stream cases by hand
`timescale 1ns/10ps
module tb_track_segment_finder_backend;
    typedef struct packed { logic [10:0] a; logic [15:0] d; logic [15:0] e; } tsf_row_type;
    tsf_row_type rows [8] = '{'{11'h000, 16'hA5C3, 16'hA5C3}, '{11'h001, 16'h5A3C, 16'h5A3C},
        '{11'h002, 16'hFFFF, 16'hFFFF}, '{11'h003, 16'h0001, 16'h0001}, '{11'h004, 16'hFFFF, 16'h003F},
        '{11'h005, 16'h01AB, 16'h00AB}, '{11'h006, 16'hFFFF, 16'h0001}, '{11'h007, 16'hFFFF, 16'h0000}};
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [10:0] avs_address = 11'h000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [69:0] wire_in = 70'h0;
    logic        frame_in = 1'b0;
    logic        beam_in = 1'b0;
    logic        err_in = 1'b0;
    logic        run_in = 1'b0;
    logic        l1_accept = 1'b0;
    logic [1:0]  l1_addr = 2'h0;
    logic        acc_req = 1'b0;
    logic [1:0]  acc_buf = 2'h0;
    logic [11:0] pixel_out;
    logic [11:0] pass_pix, m1_pix;
    logic        frame_out, beam_out, err_out, link_valid;
    logic [3:0]  fhist = 4'h0;
    logic [3:0]  ehist = 4'h0;
    logic [15:0] cyc = 16'h0;
    int          error_cnt = 0;
    int          check_count = 0;
    tsf_if bus_if ();
    tsf_host tsf_host_inst (.clk(clk), .rst_b(rst_b), .bus(bus_if), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    tsf_finder #(.MISS_ALLOW(3), .VARIANT(tsf_pkg::VAR_NORMAL)) tsf_finder_inst (.clk(clk), .rst_b(rst_b),
        .bus(bus_if), .wire_in(wire_in), .frame_in(frame_in), .beam_in(beam_in), .err_in(err_in),
        .run_in(run_in), .l1_accept(l1_accept), .l1_addr(l1_addr), .pixel_out(pixel_out),
        .frame_out(frame_out), .beam_out(beam_out), .err_out(err_out), .link_valid(link_valid));
    tsf_bus_properties tsf_bus_properties_inst (.clk(clk), .rst_b(rst_b), .cs(bus_if.cs),
        .rd_high(bus_if.rd_high), .wr_strobe(bus_if.wr_strobe), .addr(bus_if.addr),
        .wdata(bus_if.wdata), .rdata(bus_if.rdata));
    tsf_if pass_if ();
    tsf_if m1_if ();
    // pass-through and single-miss builds share the stream; their control ports stay idle
    tsf_finder #(.MISS_ALLOW(3), .VARIANT(tsf_pkg::VAR_PASS)) tsf_finder_pass_inst (.clk(clk), .rst_b(rst_b),
        .bus(pass_if), .wire_in(wire_in), .frame_in(frame_in), .beam_in(beam_in), .err_in(err_in),
        .run_in(run_in), .l1_accept(l1_accept), .l1_addr(l1_addr), .pixel_out(pass_pix),
        .frame_out(), .beam_out(), .err_out(), .link_valid());
    tsf_finder #(.MISS_ALLOW(1), .VARIANT(tsf_pkg::VAR_NORMAL)) tsf_finder_m1_inst (.clk(clk), .rst_b(rst_b),
        .bus(m1_if), .wire_in(wire_in), .frame_in(frame_in), .beam_in(beam_in), .err_in(err_in),
        .run_in(run_in), .l1_accept(l1_accept), .l1_addr(l1_addr), .pixel_out(m1_pix),
        .frame_out(), .beam_out(), .err_out(), .link_valid());
    always #50 clk = ~clk;
    // accept and its buffer index come from one process so they never disagree
    always @(posedge clk) begin
        cyc <= cyc + 16'h1;
        frame_in <= cyc[1:0] == 2'h3;
        beam_in <= cyc[1:0] == 2'h3;
        l1_accept <= acc_req && cyc[1:0] == 2'h3;
        l1_addr <= acc_buf;
        fhist <= {fhist[2:0], frame_in};
        err_in <= cyc[2];
        ehist <= {ehist[2:0], err_in};
        if (cyc == 16'h1388) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("errors=%0d checks=%0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // wait is bounded only by the cycle ceiling above
    task automatic av(input logic wr, input logic [10:0] a, input logic [15:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [10:0] a, input logic [15:0] d);
        logic [31:0] q;
        av(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [10:0] a, input logic [15:0] e, input logic [15:0] m);
        logic [31:0] q;
        av(1'b0, a, 16'h0000, q);
        chk(q & {16'hFFFF, m}, {16'h0000, e});
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    function automatic logic [11:0] pix_model(input logic [69:0] w, input int lim);
        logic [23:0] hit;
        int          miss;
        for (int m = 0; m < 24; m++) begin
            miss = 0;
            for (int k = 0; k < 12; k++) begin
                miss += !w[(3 * m + 5 * k) % 70];
            end
            hit[m] = miss <= lim;
        end
        return hit[11:0] | hit[23:12];
    endfunction
    initial begin
        logic [69:0] pats [5];
        pats = '{~70'h0, 70'h0, ~70'h421, ~70'h8421, {35{2'b10}}};
        {pass_if.cs, pass_if.rd_high, pass_if.wr_strobe, pass_if.addr, pass_if.wdata} <= {3'b010, 26'h0};
        {m1_if.cs, m1_if.rd_high, m1_if.wr_strobe, m1_if.addr, m1_if.wdata} <= {3'b010, 26'h0};
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        run_in <= 1'b1;
        @(negedge clk);
        chk(pixel_out, 12'h000);
        chk(link_valid, 1'b0);
        for (int i = 0; i < 7; i++) begin
            rdc(11'(i), 16'h0000, 16'hFFFF);
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e, 16'hFFFF);
        end
        for (int i = 0; i < 7; i++) begin
            wr(11'(i), (i == 5) ? 16'h0003 : 16'h0000);
        end
        foreach (pats[i]) begin
            @(posedge clk);
            wire_in <= pats[i];
            settle(8);
            chk(pixel_out, pix_model(pats[i], 3));
            chk(m1_pix, pix_model(pats[i], 1));
            chk(pass_pix, pats[i][11:0]);
            chk(link_valid, 1'b1);
            chk({err_out, frame_out, beam_out}, {ehist[3], {2{fhist[3]}}});
        end
        for (int i = 0; i < 5; i++) begin
            wr(11'(i), 16'hFFFF);
        end
        settle(4);
        chk(pixel_out, 12'hFFF);
        for (int i = 0; i < 5; i++) begin
            wr(11'(i), 16'h0000);
        end
        @(posedge clk);
        wire_in <= ~70'h0;
        settle(20);
        @(posedge clk);
        acc_req <= 1'b1;
        acc_buf <= 2'h1;
        repeat (4) @(posedge clk);
        acc_buf <= 2'h2;
        repeat (4) @(posedge clk);
        acc_req <= 1'b0;
        settle(12);
        // buffers 1 and 2 were filled
        for (int i = 8; i < 24; i++) begin
            rdc(11'h020 | 11'(i), i[0] ? 16'h00FF : 16'hFFFF, i[0] ? 16'hF8FF : 16'hFFFF);
        end
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        chk(link_valid, 1'b0);
        chk(pixel_out, 12'h000);
        rst_b <= 1'b1;
        rdc(11'h005, 16'h0000, 16'hFFFF);
        rdc(11'h400, 16'h0001, 16'hFFFF);
        finish_test();
    end
endmodule
